/* hw/spc_storage_cells.sv */
// storage cell primitives behind an axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "spc_map.svh"

// Functional notes
// - input latch passes pad data while gate active; gate polarity selectable per variant.
// - with gate enable variant, latch holds while gate enable is low.
// - a buffered unlatched copy of the pad data is provided.
// - input cells go to configured init value at power-on and global reset.
// - master-slave register gives slave output and master latch output.
// - logic edge cell captures on active edge; clock polarity invertible.
// - one edge variant has preset and clear, no clock enable.
// - two edge variants have clock enable and clear, no preset.
// - one edge variant has clock enable and preset only.
// - edge cell preset and clear act when high.
// - global reset sends preset variant to one, others to zero.
// - one level variant is transparent high with preset and clear, no enable.
// - other level variant is transparent high with gate enable and clear.
// - level gate polarity invertible; preset, clear and gate enable active high.
// - global reset input polarity may be inverted.
// - every cell implements the global reset input.
// - input edge cell with clock enable holds while enable is low.
module spc_storage_cells (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SPC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SPC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pad_data,
  output logic pad_copy,
  output logic latch_q,
  output logic inedge_q,
  output logic ms_q,
  output logic master_stage_out,
  output logic edge_q,
  output logic level_q
);

  spc_pkg::spc_state_t q;
  spc_pkg::spc_state_t n;

  logic gbl_reset;
  logic pad;
  logic latch_en;
  logic inedge_clk;
  logic inedge_rise;
  logic inedge_ce_ok;
  logic input_init;
  logic [1:0] edge_var;
  logic edge_has_ce;
  logic edge_has_clear;
  logic edge_has_preset;
  logic edge_clk;
  logic edge_rise;
  logic edge_clear;
  logic edge_preset;
  logic edge_load;
  logic level_has_preset;
  logic level_has_gate_en;
  logic level_clear;
  logic level_preset;
  logic level_en;
  logic do_write;
  logic [3:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [31:0] stat;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] ofs);
    return {a[3:2], 2'h0} == ofs;
  endfunction

  assign gbl_reset = q.drv[`SPC_DRV_GBL_RESET] ^ q.cfg[`SPC_CFG_GBL_RESET_INV];
  assign pad = q.pad_s2;
  assign input_init = q.cfg[`SPC_CFG_INPUT_INIT_SET];
  // gate polarity comes from its own cfg bit, the same for both input latch variants
  assign latch_en = (q.drv[`SPC_DRV_LATCH_GATE] ^ q.cfg[`SPC_CFG_LATCH_GATE_LOW])
    && (!q.cfg[`SPC_CFG_LATCH_HAS_GATE_EN] || q.drv[`SPC_DRV_LATCH_GATE_EN]);
  assign inedge_clk = q.drv[`SPC_DRV_INEDGE_CLK];
  assign inedge_rise = inedge_clk && !q.inedge_clk_prev;
  assign inedge_ce_ok = !q.cfg[`SPC_CFG_INEDGE_HAS_CE] || q.drv[`SPC_DRV_INEDGE_CE];

  assign edge_var = q.cfg[`SPC_CFG_EDGE_VAR_HI:`SPC_CFG_EDGE_VAR_LO];
  assign edge_has_ce = edge_var != `SPC_EDGE_VAR_BOTH;
  assign edge_has_clear = edge_var != `SPC_EDGE_VAR_PRESET;
  assign edge_has_preset = (edge_var == `SPC_EDGE_VAR_BOTH) ||
                           (edge_var == `SPC_EDGE_VAR_PRESET);
  assign edge_clk = q.drv[`SPC_DRV_EDGE_CLK] ^ q.cfg[`SPC_CFG_EDGE_CLK_INV];
  assign edge_rise = edge_clk && !q.edge_clk_prev;
  assign edge_clear = edge_has_clear && q.drv[`SPC_DRV_EDGE_CLEAR];
  assign edge_preset = edge_has_preset && q.drv[`SPC_DRV_EDGE_PRESET];
  assign edge_load = edge_rise && (!edge_has_ce || q.drv[`SPC_DRV_EDGE_CE]);

  assign level_has_preset = !q.cfg[`SPC_CFG_LEVEL_VAR];
  assign level_has_gate_en = q.cfg[`SPC_CFG_LEVEL_VAR];
  assign level_clear = q.drv[`SPC_DRV_LEVEL_CLEAR];
  assign level_preset = level_has_preset && q.drv[`SPC_DRV_LEVEL_PRESET];
  assign level_en = (q.drv[`SPC_DRV_LEVEL_GATE] ^ q.cfg[`SPC_CFG_LEVEL_GATE_INV])
    && (!level_has_gate_en || q.drv[`SPC_DRV_LEVEL_GATE_EN]);

  assign do_write = (q.wr_state == spc_pkg::SPC_WR_IDLE && s_axi_awvalid && s_axi_wvalid) ||
                    (q.wr_state == spc_pkg::SPC_WR_ADDR && s_axi_wvalid) ||
                    (q.wr_state == spc_pkg::SPC_WR_DATA && s_axi_awvalid);
  assign wa = (q.wr_state == spc_pkg::SPC_WR_ADDR) ? q.waddr : s_axi_awaddr;
  assign wd = (q.wr_state == spc_pkg::SPC_WR_DATA) ? q.wdata : s_axi_wdata;
  assign ws = (q.wr_state == spc_pkg::SPC_WR_DATA) ? q.wstrb : s_axi_wstrb;
  assign stat = {25'h0, q.level_q, q.edge_q, q.ms_master, q.ms_q, q.inedge_q,
                 q.pad_s2, q.latch_q};

  always_comb begin
    n = q;
    // pad data crosses in through two flops; only the second is read
    n.pad_s1 = pad_data;
    n.pad_s2 = q.pad_s1;
    n.inedge_clk_prev = inedge_clk;
    n.edge_clk_prev = edge_clk;

    if (latch_en) begin
      n.latch_q = pad;
    end
    if (inedge_rise && inedge_ce_ok) begin
      n.inedge_q = pad;
    end
    // master is open while the shared clock is low, slave takes it at the edge
    if (!inedge_clk) begin
      n.ms_master = pad;
    end
    if (inedge_rise) begin
      n.ms_q = q.ms_master;
    end

    if (edge_clear) begin
      n.edge_q = 1'b0;
    end else if (edge_preset) begin
      n.edge_q = 1'b1;
    end else if (edge_load) begin
      n.edge_q = q.drv[`SPC_DRV_EDGE_D];
    end

    if (level_clear) begin
      n.level_q = 1'b0;
    end else if (level_preset) begin
      n.level_q = 1'b1;
    end else if (level_en) begin
      n.level_q = q.drv[`SPC_DRV_LEVEL_D];
    end

    // global reset comes last so it overrides every other input
    if (gbl_reset) begin
      n.latch_q = input_init;
      n.inedge_q = input_init;
      n.ms_master = input_init;
      n.ms_q = input_init;
      n.edge_q = edge_var == `SPC_EDGE_VAR_PRESET;
      n.level_q = 1'b0;
    end

    case (q.wr_state)
      spc_pkg::SPC_WR_IDLE: begin
        if (s_axi_awvalid && !s_axi_wvalid) begin
          n.waddr = s_axi_awaddr;
          n.wr_state = spc_pkg::SPC_WR_ADDR;
        end else if (s_axi_wvalid && !s_axi_awvalid) begin
          n.wdata = s_axi_wdata;
          n.wstrb = s_axi_wstrb;
          n.wr_state = spc_pkg::SPC_WR_DATA;
        end
      end
      spc_pkg::SPC_WR_ADDR, spc_pkg::SPC_WR_DATA: begin
      end
      spc_pkg::SPC_WR_RESP: begin
        if (s_axi_bready) begin
          n.wr_state = spc_pkg::SPC_WR_IDLE;
        end
      end
      default: begin
        n.wr_state = spc_pkg::SPC_WR_IDLE;
      end
    endcase

    if (do_write) begin
      n.wr_state = spc_pkg::SPC_WR_RESP;
      n.bresp = `SPC_RESP_OKAY;
      if (is_reg(wa, `SPC_CFG_OFS)) begin
        n.cfg = merge(q.cfg, wd, ws);
      end else if (is_reg(wa, `SPC_DRV_OFS)) begin
        n.drv = merge(q.drv, wd, ws);
      end else if (!is_reg(wa, `SPC_STAT_OFS)) begin
        n.bresp = `SPC_RESP_SLVERR;
      end
    end

    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end else if (!q.rvalid && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `SPC_RESP_OKAY;
      if (is_reg(s_axi_araddr, `SPC_CFG_OFS)) begin
        n.rdata = q.cfg;
      end else if (is_reg(s_axi_araddr, `SPC_DRV_OFS)) begin
        n.rdata = q.drv;
      end else if (is_reg(s_axi_araddr, `SPC_STAT_OFS)) begin
        n.rdata = stat;
      end else begin
        n.rdata = 32'h0000_0000;
        n.rresp = `SPC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // power-on state matches a global reset with the default configuration
      q <= '0;
      q.wr_state <= spc_pkg::SPC_WR_IDLE;
      q.cfg <= `SPC_CFG_RST;
      q.drv <= `SPC_DRV_RST;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = (q.wr_state == spc_pkg::SPC_WR_IDLE) ||
                         (q.wr_state == spc_pkg::SPC_WR_DATA);
  assign s_axi_wready = (q.wr_state == spc_pkg::SPC_WR_IDLE) ||
                        (q.wr_state == spc_pkg::SPC_WR_ADDR);
  assign s_axi_bvalid = q.wr_state == spc_pkg::SPC_WR_RESP;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign pad_copy = q.pad_s2;
  assign latch_q = q.latch_q;
  assign inedge_q = q.inedge_q;
  assign ms_q = q.ms_q;
  assign master_stage_out = q.ms_master;
  assign edge_q = q.edge_q;
  assign level_q = q.level_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_latch_pass;
    latch_en && !gbl_reset |=> latch_q == $past(pad);
  endproperty
  a_latch_pass: assert property (p_latch_pass) else $error("latch did not pass data");

  property p_latch_hold;
    q.cfg[`SPC_CFG_LATCH_HAS_GATE_EN] && !q.drv[`SPC_DRV_LATCH_GATE_EN] && !gbl_reset
      |=> $stable(latch_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved without enable");

  property p_pad_copy;
    ##3 pad_copy == $past(pad_data, 2);
  endproperty
  a_pad_copy: assert property (p_pad_copy) else $error("pad copy wrong or late");

  property p_input_init;
    gbl_reset |=> latch_q == $past(input_init) && ms_q == $past(input_init)
                  && inedge_q == $past(input_init);
  endproperty
  a_input_init: assert property (p_input_init) else $error("input cell init wrong");

  property p_ms_slave;
    inedge_rise && !gbl_reset |=> ms_q == $past(master_stage_out);
  endproperty
  a_ms_slave: assert property (p_ms_slave) else $error("slave did not take master");

  property p_edge_capture;
    edge_load && !edge_clear && !edge_preset && !gbl_reset
      |=> edge_q == $past(q.drv[`SPC_DRV_EDGE_D]);
  endproperty
  a_edge_capture: assert property (p_edge_capture) else $error("edge cell missed data");

  property p_clear_wins;
    edge_clear && !gbl_reset |=> !edge_q;
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("clear did not win");

  property p_edge_init;
    gbl_reset |=> edge_q == ($past(edge_var) == `SPC_EDGE_VAR_PRESET) && !level_q;
  endproperty
  a_edge_init: assert property (p_edge_init) else $error("logic cell init wrong");

  property p_level_pass;
    level_en && !level_clear && !level_preset && !gbl_reset
      |=> level_q == $past(q.drv[`SPC_DRV_LEVEL_D]);
  endproperty
  a_level_pass: assert property (p_level_pass) else $error("level cell not transparent");

  property p_inedge_hold;
    !inedge_ce_ok && !gbl_reset |=> $stable(inedge_q);
  endproperty
  a_inedge_hold: assert property (p_inedge_hold) else $error("edge cell moved without ce");

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");

  property p_cov_write;
    s_axi_awvalid && s_axi_wvalid ##1 s_axi_bvalid;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_ms;
    inedge_rise && !gbl_reset ##1 ms_q != inedge_q;
  endproperty
  c_cov_ms: cover property (p_cov_ms);

  property p_cov_preset_init;
    gbl_reset && edge_var == `SPC_EDGE_VAR_PRESET ##1 edge_q;
  endproperty
  c_cov_preset_init: cover property (p_cov_preset_init);

endmodule
`default_nettype wire

/* inc/spc_map.svh */
// register offsets, field positions and reset values of the storage cell block
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

`define SPC_ADDR_W 4
`define SPC_CFG_OFS 4'h0
`define SPC_DRV_OFS 4'h4
`define SPC_STAT_OFS 4'h8

`define SPC_CFG_RST 32'h0000_0000
`define SPC_DRV_RST 32'h0000_0000

// configuration fields
`define SPC_CFG_LATCH_GATE_LOW 0
`define SPC_CFG_LATCH_HAS_GATE_EN 1
`define SPC_CFG_INPUT_INIT_SET 2
`define SPC_CFG_EDGE_CLK_INV 3
`define SPC_CFG_EDGE_VAR_LO 4
`define SPC_CFG_EDGE_VAR_HI 5
`define SPC_CFG_LEVEL_VAR 6
`define SPC_CFG_LEVEL_GATE_INV 7
`define SPC_CFG_GBL_RESET_INV 8
`define SPC_CFG_INEDGE_HAS_CE 9

// drive fields
`define SPC_DRV_LATCH_GATE 0
`define SPC_DRV_LATCH_GATE_EN 1
`define SPC_DRV_INEDGE_CLK 2
`define SPC_DRV_INEDGE_CE 3
`define SPC_DRV_EDGE_D 4
`define SPC_DRV_EDGE_CLK 5
`define SPC_DRV_EDGE_CE 6
`define SPC_DRV_EDGE_CLEAR 7
`define SPC_DRV_EDGE_PRESET 8
`define SPC_DRV_LEVEL_D 9
`define SPC_DRV_LEVEL_GATE 10
`define SPC_DRV_LEVEL_GATE_EN 11
`define SPC_DRV_LEVEL_CLEAR 12
`define SPC_DRV_LEVEL_PRESET 13
`define SPC_DRV_GBL_RESET 14

// edge cell variants
`define SPC_EDGE_VAR_BOTH 2'h0
`define SPC_EDGE_VAR_PRESET 2'h2

`define SPC_RESP_OKAY 2'h0
`define SPC_RESP_SLVERR 2'h2

`endif

/* inc/spc_pkg.sv */
// types of the storage cell block
package spc_pkg;

  typedef enum logic [1:0] {
    SPC_WR_IDLE,
    SPC_WR_ADDR,
    SPC_WR_DATA,
    SPC_WR_RESP
  } spc_wr_state_t;

  typedef struct packed {
    spc_wr_state_t wr_state;
    logic [3:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cfg;
    logic [31:0] drv;
    logic pad_s1;
    logic pad_s2;
    logic inedge_clk_prev;
    logic edge_clk_prev;
    logic latch_q;
    logic inedge_q;
    logic ms_master;
    logic ms_q;
    logic edge_q;
    logic level_q;
  } spc_state_t;

endpackage

/* test/spc_pad_model.sv */
// pad driver standing in for the off-chip signal that feeds the input cells
`timescale 1ns/100ps
`default_nettype none
module spc_pad_model (
  input wire logic want,
  input wire logic slow,
  output logic pad_data
);
  // moves off the clock edge; slow mode lands past the next edge
  initial begin
    pad_data = 1'b0;
    forever begin
      @(want);
      if (slow) begin
        #11 pad_data = want;
      end else begin
        #3 pad_data = want;
      end
    end
  end
endmodule
`default_nettype wire

/* test/storage_primitive_cells_test.sv */
// self-checking bench for the storage cell block
`timescale 1ns/100ps
`default_nettype none
`include "spc_map.svh"
module storage_primitive_cells_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic want = 1'b0;
  logic slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pad_data, pad_copy;
  logic latch_q, inedge_q, ms_q, master_stage_out, edge_q, level_q, b, e;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_d, dv, rv;
  logic [3:0] rs;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'hef6d;

  spc_storage_cells uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pad_data(pad_data), .pad_copy(pad_copy),
    .latch_q(latch_q), .inedge_q(inedge_q), .ms_q(ms_q),
    .master_stage_out(master_stage_out), .edge_q(edge_q), .level_q(level_q));

  spc_pad_model pad (.want(want), .slow(slow), .pad_data(pad_data));

  always #4 aclk = ~aclk;

  // the whole run needs several hundred cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask

  task automatic chkb(input string n, input logic x, input logic g);
    compares++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %s exp %b got %b", n, x, g);
    end
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction

  function automatic logic has_pre(input int v);
    return v == 0 || v == 2;
  endfunction

  function automatic logic has_clr(input int v);
    return v != 2;
  endfunction

  // one channel may lag a cycle and bready may wait for bvalid, so every write state is reached
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done;
    logic w_done;
    logic [2:0] k;
    aw_done = 1'b0;
    w_done = 1'b0;
    k = 3'($random(seed));
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= !(k[0] && k[1]);
    wvalid <= !(k[0] && !k[1]);
    bready <= k[2];
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end else if (!aw_done) begin
        awvalid <= 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end else if (!w_done) begin
        wvalid <= 1'b1;
      end
      if (bvalid && !bready) begin
        bready <= 1'b1;
      end
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // cells follow a register write one edge later
  task automatic cfg(input logic [31:0] d);
    wr(`SPC_CFG_OFS, d, 4'hf);
    repeat (3) @(posedge aclk);
  endtask

  task automatic drv(input logic [31:0] d);
    wr(`SPC_DRV_OFS, d, 4'hf);
    repeat (3) @(posedge aclk);
  endtask

  // pad crosses a two-flop synchroniser before the cells see it
  task automatic pad_to(input logic v);
    want <= v;
    slow <= 1'($random(seed));
    repeat (5) @(posedge aclk);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SPC_CFG_OFS);
    chk("cfg", `SPC_CFG_RST, rd_d);
    rd(`SPC_DRV_OFS);
    chk("drv", `SPC_DRV_RST, rd_d);
    rd(`SPC_STAT_OFS);
    chk("stat", 32'h0, rd_d);
    wr(4'hc, 32'h1, 4'hf);
    chk("bresp", 32'(`SPC_RESP_SLVERR), 32'(resp));
    rd(4'hc);
    chk("rresp", 32'(`SPC_RESP_SLVERR), 32'(resp));
    chk("rdata", 32'h0, rd_d);
    wr(`SPC_STAT_OFS, 32'hff, 4'hf);
    chk("bresp", 32'(`SPC_RESP_OKAY), 32'(resp));
    rd(`SPC_STAT_OFS);
    chk("stat", 32'h0, rd_d);
    dv = 32'h0;
    repeat (8) begin
      rv = $random(seed) & 32'h3fff;
      rs = 4'($random(seed));
      wr(`SPC_DRV_OFS, rv, rs);
      dv = merge(dv, rv, rs);
      rd(`SPC_DRV_OFS);
      chk("drv", dv, rd_d);
    end
    cfg(32'h0);
    pad_to(1'b1);
    drv(32'h1);
    chkb("latch", 1'b1, latch_q);
    chkb("copy", 1'b1, pad_copy);
    pad_to(1'b0);
    chkb("latch", 1'b0, latch_q);
    chkb("copy", 1'b0, pad_copy);
    drv(32'h0);
    pad_to(1'b1);
    chkb("latch", 1'b0, latch_q);
    cfg(32'h1);
    chkb("latch", 1'b1, latch_q);
    cfg(32'h3);
    pad_to(1'b0);
    chkb("latch", 1'b1, latch_q);
    drv(32'h2);
    chkb("latch", 1'b0, latch_q);
    cfg(32'h0);
    drv(32'h0);
    pad_to(1'b1);
    chkb("master", 1'b1, master_stage_out);
    drv(32'h4);
    chkb("ms", 1'b1, ms_q);
    chkb("inedge", 1'b1, inedge_q);
    pad_to(1'b0);
    chkb("master", 1'b1, master_stage_out);
    drv(32'h0);
    chkb("master", 1'b0, master_stage_out);
    chkb("ms", 1'b1, ms_q);
    cfg(32'h200);
    drv(32'h4);
    chkb("inedge", 1'b1, inedge_q);
    drv(32'h0);
    drv(32'hc);
    chkb("inedge", 1'b0, inedge_q);
    for (int v = 0; v < 4; v++) begin
      cfg(32'(v) << 4);
      drv(32'h4000);
      chkb("edge_gr", has_pre(v) && !has_clr(v), edge_q);
      b = 1'($random(seed));
      drv(32'h40 | 32'(b) << 4);
      drv(32'h60 | 32'(b) << 4);
      chkb("edge_d", b, edge_q);
      drv(32'(!b) << 4);
      drv(32'h20 | 32'(!b) << 4);
      e = (v == 0) ? !b : b;
      chkb("edge_ce", e, edge_q);
      drv(32'h80);
      e = has_clr(v) ? 1'b0 : e;
      chkb("edge_clr", e, edge_q);
      drv(32'h100);
      e = has_pre(v) ? 1'b1 : e;
      chkb("edge_pre", e, edge_q);
      drv(32'h180);
      chkb("edge_both", !has_clr(v), edge_q);
    end
    cfg(32'h8);
    drv(32'h30);
    chkb("edge_inv", 1'b0, edge_q);
    drv(32'h10);
    chkb("edge_inv", 1'b1, edge_q);
    cfg(32'h0);
    drv(32'h600);
    chkb("level", 1'b1, level_q);
    drv(32'h0);
    chkb("level", 1'b1, level_q);
    drv(32'h3000);
    chkb("level", 1'b0, level_q);
    drv(32'h2000);
    chkb("level", 1'b1, level_q);
    cfg(32'h80);
    drv(32'h0);
    chkb("level", 1'b0, level_q);
    cfg(32'h40);
    drv(32'h600);
    chkb("level", 1'b0, level_q);
    drv(32'he00);
    chkb("level", 1'b1, level_q);
    drv(32'h2000);
    chkb("level", 1'b1, level_q);
    drv(32'h1000);
    chkb("level", 1'b0, level_q);
    cfg(32'h4);
    pad_to(1'b0);
    drv(32'h4001);
    rd(`SPC_STAT_OFS);
    chk("stat", 32'h1d, rd_d);
    cfg(32'h104);
    chkb("latch", 1'b0, latch_q);
    drv(32'h0);
    chkb("latch", 1'b1, latch_q);
    stop_test();
  end
endmodule
`default_nettype wire
